// ==== core/pers_pkg.sv ====
// Package for the power, charger and reset sequencer
package pers_pkg;

  // Reset pin filter window on the 50 MHz core clock
  localparam int unsigned RST_FILT_MIN_US = 1500;
  localparam int unsigned CLK_KHZ = 50000;
  // Filter time chosen inside the 1.5 to 4.0 ms window
  localparam int unsigned RST_FILT_US = 2000;
  localparam int unsigned RST_FILT_CYC = RST_FILT_US * (CLK_KHZ / 1000);
  localparam int unsigned RST_PIN_HOLD_MS = 5;

  // Pull codes for pad control outputs
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;

  // Reset values
  localparam logic [3:0] ICHG_RST = 4'h0;
  // Synchroniser image: reset pin idles high, the rest low
  localparam logic [7:0] SYNC_RST = 8'h20;

  typedef enum logic [2:0]
  {
    CHG_OFF = 3'b000,
    CHG_TRICKLE = 3'b001,
    CHG_FAST_CC = 3'b010,
    CHG_FAST_CV = 3'b011,
    CHG_STANDBY = 3'b100
  } pers_chg_state_type;

  // Charger comparator outputs
  typedef struct packed
  {
    logic supply_ok;
    logic above_trickle;
    logic at_float;
    logic full;
    logic below_recharge;
  } pers_chg_cmp_type;

  // Regulator control outputs
  typedef struct packed
  {
    logic smps_en;
    logic smps_lp;
    logic core_en;
    logic core_lp;
    logic audio_en;
    logic audio_lp;
  } pers_reg_ctl_type;

  // Pull settings of the reset-controlled pads
  typedef struct packed
  {
    logic [1:0] uart_rx;
    logic [1:0] uart_cts;
    logic [1:0] uart_tx;
    logic [1:0] uart_rts;
    logic [1:0] spi_mosi;
    logic [1:0] spi_clk;
    logic [1:0] spi_cs;
    logic [1:0] spi_miso;
    logic [1:0] rst_pin;
    logic [1:0] test_en;
    logic [1:0] programmable_io_pins;
  } pers_pull_type;

endpackage

// ==== core/pers_sequencer.sv ====
// Power enable, charger state and reset sequencer
//
// Behaviour
// - Switcher on when its pin, firmware or charger requests it.
// - Switcher in pulse-skipping mode during deep sleep or reset.
// - Core linear on when linear pin, firmware or charger requests it.
// - Core linear in low-power mode during deep sleep or reset.
// - Audio linear enabled like core; low power when no audio or reset.
// - Switcher pin drives switcher only; linear pin drives both linears.
// - Enable pins active high, weakly pulled down when undriven.
// - Pins start boot, firmware latches regulators, pins may then release.
// - Switcher pin level readable by firmware as a general input.
// - Charger goes off whenever its supply disappears.
// - Trickle charge below the trickle threshold.
// - Fast constant current above threshold at adjustable setting.
// - Constant voltage once the float target is reached.
// - Standby when full; back to fast charge below recharge level.
// - Charger supply presence shown on a status bit.
// - Reset from pin, power-on, serial break or watchdog.
// - Reset pin filtered; reset taken 1.5 to 4.0 ms after assertion.
// - During reset, bidirectional pins are inputs, outputs high impedance.
// - After reset assume highest crystal frequency, slow safe clocks.
// - Fixed pull-ups and pull-downs on listed pins during reset.
// - Warm reset keeps data rate and RAM; cold reset does not.
// - I/O powered before core gives weak pull-down on every I/O.
`timescale 1ns/1ps

module pers_sequencer
  import pers_pkg::*;
#(
  parameter int unsigned FILT_CYC = RST_FILT_CYC,
  parameter int unsigned ICHG_W = 4
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Enable pins
  input wire logic switcher_enable_pin,
  input wire logic linear_enable_pin,
  // Firmware requests and chip modes
  input wire logic fw_switcher_req,
  input wire logic fw_linear_req,
  input wire logic fw_latch_regs,
  input wire logic deep_sleep,
  input wire logic audio_cells_on,
  input wire logic [ICHG_W-1:0] fast_charge_current_setting,
  // Charger comparators
  input wire pers_chg_cmp_type chg_cmp,
  // Reset sources and early I/O supply flag
  input wire logic rst_pin_b,
  input wire logic por_active,
  input wire logic uart_break,
  input wire logic wdog_expire,
  input wire logic io_before_core,
  // Regulator control
  output pers_reg_ctl_type reg_ctl,
  // Charger outputs
  output pers_chg_state_type chg_state,
  output logic chg_supply_present,
  output logic [ICHG_W-1:0] chg_current,
  output logic chg_trickle_on,
  output logic chg_cv_on,
  // Status and reset
  output logic switcher_pin_status,
  output logic chip_reset,
  output logic cold_reset,
  output logic clk_safe_slow,
  output logic pads_input_only,
  output pers_pull_type pad_pull
);

  // ****************************************************
  // Synchronisers
  // ****************************************************
  localparam int SW = 8;
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  wire [SW-1:0] raw_in = {switcher_enable_pin, linear_enable_pin,
    rst_pin_b, chg_cmp};

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      // A zero on the reset bit would look like a press after reset
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // Undriven enable pins read low through the pad pull-down; the reset pin reads high
  wire pin_sw = sync2_r[7];
  wire pin_lin = sync2_r[6];
  wire pin_rst_b = sync2_r[5];
  wire supply_ok = sync2_r[4];
  wire above_trk = sync2_r[3];
  wire at_float = sync2_r[2];
  wire full = sync2_r[1];
  wire below_rech = sync2_r[0];

  // ****************************************************
  // Reset pin filter and reset sources
  // ****************************************************
  localparam int CW = $clog2(FILT_CYC + 1);
  logic [CW-1:0] filt_cnt_r;
  logic [CW-1:0] filt_cnt_nxt;
  logic pin_rst_r;
  logic chip_reset_r;
  logic cold_reset_r;

  // Saturate so a long press cannot wrap and fire a second time
  wire filt_full = (filt_cnt_r == CW'(FILT_CYC));
  // Count must run full while pin stays low; glitches restart it
  assign filt_cnt_nxt = pin_rst_b ? '0 :
    filt_full ? filt_cnt_r : filt_cnt_r + 1'b1;
  wire pin_fire = !pin_rst_b && (filt_cnt_r == CW'(FILT_CYC - 1));
  wire rst_req = pin_rst_r || por_active || uart_break || wdog_expire;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      filt_cnt_r <= '0;
      pin_rst_r <= 1'b0;
      chip_reset_r <= 1'b1;
      cold_reset_r <= 1'b1;
    end
    else
    begin
      filt_cnt_r <= filt_cnt_nxt;
      pin_rst_r <= pin_fire || (pin_rst_r && !pin_rst_b);
      chip_reset_r <= rst_req;
      // Only power-on loses data rate and RAM
      cold_reset_r <= por_active || (cold_reset_r && rst_req);
    end
  end

  // ****************************************************
  // Regulator enables
  // ****************************************************
  logic latch_sw_r;
  logic latch_lin_r;
  pers_reg_ctl_type reg_nxt;
  pers_reg_ctl_type reg_r;
  // A live charger supply keeps every regulator up
  wire chg_req = supply_ok;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      latch_sw_r <= 1'b0;
      latch_lin_r <= 1'b0;
    end
    else if (chip_reset_r)
    begin
      latch_sw_r <= 1'b0;
      latch_lin_r <= 1'b0;
    end
    else if (fw_latch_regs)
    begin
      // Latch whatever the pins have powered up, then pins may drop
      latch_sw_r <= latch_sw_r || pin_sw;
      latch_lin_r <= latch_lin_r || pin_lin;
    end
  end

  wire fw_sw = fw_switcher_req || latch_sw_r;
  wire fw_lin = fw_linear_req || latch_lin_r;

  // Pin, firmware or charger can each turn a regulator on
  function automatic logic reg_request(
    input logic pin,
    input logic fw,
    input logic chg
  );
    return pin || fw || chg;
  endfunction

  // Low power while idle or held in reset
  function automatic logic reg_low_power(
    input logic idle,
    input logic in_reset
  );
    return idle || in_reset;
  endfunction

  always_comb
  begin
    reg_nxt.smps_en = reg_request(pin_sw, fw_sw, chg_req);
    reg_nxt.smps_lp = reg_low_power(deep_sleep, chip_reset_r);
    reg_nxt.core_en = reg_request(pin_lin, fw_lin, chg_req);
    reg_nxt.core_lp = reg_low_power(deep_sleep, chip_reset_r);
    reg_nxt.audio_en = reg_request(pin_lin, fw_lin, chg_req);
    reg_nxt.audio_lp = reg_low_power(!audio_cells_on, chip_reset_r);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      reg_r <= '0;
    else
      reg_r <= reg_nxt;
  end

  // ****************************************************
  // Charger state machine
  // ****************************************************
  pers_chg_state_type chg_r;
  pers_chg_state_type chg_nxt;
  logic [ICHG_W-1:0] ichg_r;

  always_comb
  begin
    chg_nxt = chg_r;
    if (!supply_ok)
      chg_nxt = CHG_OFF;
    else
    begin
      case (chg_r)
        CHG_OFF:
          chg_nxt = above_trk ? CHG_FAST_CC : CHG_TRICKLE;
        CHG_TRICKLE:
          if (above_trk)
            chg_nxt = CHG_FAST_CC;
        CHG_FAST_CC:
          if (!above_trk)
            chg_nxt = CHG_TRICKLE;
          else if (at_float)
            chg_nxt = CHG_FAST_CV;
        CHG_FAST_CV:
          if (full)
            chg_nxt = CHG_STANDBY;
        CHG_STANDBY:
          if (below_rech)
            chg_nxt = CHG_FAST_CC;
        default:
          chg_nxt = CHG_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      chg_r <= CHG_OFF;
      ichg_r <= ICHG_W'(ICHG_RST);
    end
    else
    begin
      chg_r <= chg_nxt;
      ichg_r <= fast_charge_current_setting;
    end
  end

  // ****************************************************
  // Pad states and status outputs
  // ****************************************************
  logic sw_status_r;
  logic sup_r;
  logic trk_r;
  logic cv_r;
  logic [ICHG_W-1:0] cur_r;
  logic pads_in_r;
  logic slow_r;
  pers_pull_type pull_r;
  pers_pull_type pull_nxt;

  // Flags follow the state being entered, so they change with chg_state
  wire nxt_trickle = (chg_nxt == CHG_TRICKLE);
  wire nxt_cc = (chg_nxt == CHG_FAST_CC);
  wire nxt_cv = (chg_nxt == CHG_FAST_CV);

  // Reset table pulls; early I/O supply overrides with all pull-down
  always_comb
  begin
    pull_nxt = '0;
    if (io_before_core)
      pull_nxt = {11{PULL_DOWN}};
    else if (chip_reset_r)
    begin
      pull_nxt.uart_rx = PULL_DOWN;
      pull_nxt.uart_cts = PULL_DOWN;
      pull_nxt.uart_tx = PULL_UP;
      pull_nxt.uart_rts = PULL_UP;
      pull_nxt.spi_mosi = PULL_DOWN;
      pull_nxt.spi_clk = PULL_DOWN;
      pull_nxt.spi_cs = PULL_UP;
      pull_nxt.spi_miso = PULL_DOWN;
      pull_nxt.rst_pin = PULL_UP;
      pull_nxt.test_en = PULL_DOWN;
      pull_nxt.programmable_io_pins = PULL_DOWN;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sw_status_r <= 1'b0;
      sup_r <= 1'b0;
      trk_r <= 1'b0;
      cv_r <= 1'b0;
      cur_r <= '0;
      pads_in_r <= 1'b1;
      slow_r <= 1'b1;
      pull_r <= '0;
    end
    else
    begin
      sw_status_r <= pin_sw;
      sup_r <= supply_ok;
      trk_r <= nxt_trickle;
      cv_r <= nxt_cv;
      cur_r <= nxt_cc ? ichg_r : '0;
      pads_in_r <= chip_reset_r;
      // Safe slow clock held high from reset on; no input ever clears it
      slow_r <= chip_reset_r || slow_r;
      pull_r <= pull_nxt;
    end
  end

  assign reg_ctl = reg_r;
  assign chg_state = chg_r;
  assign chg_supply_present = sup_r;
  assign chg_current = cur_r;
  assign chg_trickle_on = trk_r;
  assign chg_cv_on = cv_r;
  assign switcher_pin_status = sw_status_r;
  assign chip_reset = chip_reset_r;
  assign cold_reset = cold_reset_r;
  assign clk_safe_slow = slow_r;
  assign pads_input_only = pads_in_r;
  assign pad_pull = pull_r;

endmodule // pers_sequencer

// ==== tb/pers_properties.sv ====
// Port checker of the sequencer
`timescale 1ns/1ps
module pers_checker
  import pers_pkg::*;
#(
  parameter int unsigned FILT_CYC = 20
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Inputs
  input wire logic switcher_enable_pin,
  input wire logic linear_enable_pin,
  input wire logic fw_switcher_req,
  input wire logic fw_linear_req,
  input wire logic deep_sleep,
  input wire pers_chg_cmp_type chg_cmp,
  input wire logic rst_pin_b,
  input wire logic por_active,
  input wire logic uart_break,
  input wire logic wdog_expire,
  // Outputs
  input wire pers_reg_ctl_type reg_ctl,
  input wire pers_chg_state_type chg_state,
  input wire logic switcher_pin_status,
  input wire logic chip_reset
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // Length of the current low stretch on the reset pin
  int unsigned low_r;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || rst_pin_b)
      low_r <= 0;
    else
      low_r <= low_r + 1;
  end
  property p_src;
    (por_active || uart_break || wdog_expire) |-> ##[1:2] chip_reset;
  endproperty
  a_src: assert property (p_src) else $error("src");
  property p_fsw;
    fw_switcher_req [*4] |-> reg_ctl.smps_en;
  endproperty
  a_fsw: assert property (p_fsw) else $error("fsw");
  property p_fln;
    fw_linear_req [*4] |-> reg_ctl.core_en && reg_ctl.audio_en;
  endproperty
  a_fln: assert property (p_fln) else $error("fln");
  property p_slp;
    deep_sleep [*4] |-> reg_ctl.smps_lp && reg_ctl.core_lp;
  endproperty
  a_slp: assert property (p_slp) else $error("slp");
  property p_lpin;
    linear_enable_pin [*5] |-> reg_ctl.core_en && reg_ctl.audio_en;
  endproperty
  a_lpin: assert property (p_lpin) else $error("lpin");
  property p_hpin;
    switcher_enable_pin [*5] |-> reg_ctl.smps_en && switcher_pin_status;
  endproperty
  a_hpin: assert property (p_hpin) else $error("hpin");
  property p_off;
    !chg_cmp.supply_ok [*5] |-> chg_state == CHG_OFF;
  endproperty
  a_off: assert property (p_off) else $error("off");
  property p_filt;
    low_r > FILT_CYC + 3 |-> chip_reset;
  endproperty
  a_filt: assert property (p_filt) else $error("filt");
endmodule // pers_checker

bind pers_sequencer pers_checker #(.FILT_CYC(FILT_CYC)) u_chk (.core_clk,
  .rst_b, .switcher_enable_pin, .linear_enable_pin, .fw_switcher_req,
  .fw_linear_req, .deep_sleep, .chg_cmp, .rst_pin_b, .por_active,
  .uart_break, .wdog_expire, .reg_ctl, .chg_state, .switcher_pin_status,
  .chip_reset);

// ==== tb/pers_board.sv ====
// Board pin drivers and charger supply model
`timescale 1ns/1ps
module pers_board
  import pers_pkg::*;
#(
  parameter logic [12:0] FLOAT_MV = 13'h1068
)
(
  // Bench controls
  input wire logic sw_drive,
  input wire logic lin_drive,
  input wire logic rst_drive,
  input wire logic plug,
  input wire logic taper,
  input wire logic [12:0] bat_mv,
  // Pins
  output logic switcher_enable_pin,
  output logic linear_enable_pin,
  output logic rst_pin_b,
  output pers_chg_cmp_type chg_cmp
);
  // Released pins settle to their pulls
  assign switcher_enable_pin = sw_drive;
  assign linear_enable_pin = lin_drive;
  assign rst_pin_b = !rst_drive;
  assign chg_cmp.supply_ok = plug;
  // No supply, no comparator output
  assign chg_cmp.above_trickle = plug && bat_mv > 13'hb54;
  assign chg_cmp.at_float = plug && bat_mv >= FLOAT_MV;
  assign chg_cmp.full = chg_cmp.at_float && taper;
  assign chg_cmp.below_recharge = plug && bat_mv < FLOAT_MV - 13'h96;
endmodule // pers_board

// ==== tb/tb_top.sv ====
// Self-checking bench of the sequencer
`timescale 1ns/1ps
module tb_top;
  import pers_pkg::*;
  localparam int unsigned FILT = 20;
  localparam logic [3:0] UD = {PULL_UP, PULL_DOWN};
  localparam logic [3:0] DD = {PULL_DOWN, PULL_DOWN};
  logic core_clk = 1'h0, rst_b = 1'h0, fw_latch_regs = 1'h0;
  logic fw_switcher_req = 1'h0, fw_linear_req = 1'h0, deep_sleep = 1'h0;
  logic audio_cells_on = 1'h1, io_before_core = 1'h0, por_active = 1'h0;
  logic uart_break = 1'h0, wdog_expire = 1'h0, plug = 1'h0, taper = 1'h0;
  logic sw_drive = 1'h0, lin_drive = 1'h0, rst_drive = 1'h0;
  logic [12:0] bat_mv = 13'h0;
  logic [3:0] fast_charge_current_setting = 4'h0, chg_current;
  logic switcher_enable_pin, linear_enable_pin, rst_pin_b, chg_cv_on;
  logic chg_supply_present, chg_trickle_on, switcher_pin_status;
  logic chip_reset, cold_reset, clk_safe_slow, pads_input_only;
  pers_chg_cmp_type chg_cmp;
  pers_reg_ctl_type reg_ctl;
  pers_chg_state_type chg_state;
  pers_pull_type pad_pull;
  int errors = 0, n_tests = 0;
  wire [3:0] ens = {1'h0, reg_ctl.smps_en, reg_ctl.core_en, reg_ctl.audio_en};
  wire [3:0] lps = {1'h0, reg_ctl.smps_lp, reg_ctl.core_lp, reg_ctl.audio_lp};

  always #10 core_clk = ~core_clk;

  pers_board board (.sw_drive, .lin_drive, .rst_drive, .plug, .taper,
    .bat_mv, .switcher_enable_pin, .linear_enable_pin, .rst_pin_b, .chg_cmp);

  pers_sequencer #(.FILT_CYC(FILT)) dut (.core_clk, .rst_b,
    .switcher_enable_pin, .linear_enable_pin, .fw_switcher_req,
    .fw_linear_req, .fw_latch_regs, .deep_sleep, .audio_cells_on,
    .fast_charge_current_setting, .chg_cmp, .rst_pin_b, .por_active,
    .uart_break, .wdog_expire, .io_before_core, .reg_ctl, .chg_state,
    .chg_supply_present, .chg_current, .chg_trickle_on, .chg_cv_on,
    .switcher_pin_status, .chip_reset, .cold_reset, .clk_safe_slow,
    .pads_input_only, .pad_pull);

  function automatic logic [3:0] z(input logic x);
    return {3'h0, x};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic test_done;
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wait_rst(input int lim);
    for (int i = 0; i < lim && chip_reset !== 1'h1; i++)
      cyc(1);
    chk("chip_reset", 4'h1, z(chip_reset));
    if (chip_reset !== 1'h1)
      test_done();
  endtask
  task automatic step(input logic [12:0] mv, input pers_chg_state_type st);
    bat_mv = mv;
    cyc(6);
    chk("chg_state", {1'h0, st}, {1'h0, chg_state});
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_boot;
    sw_drive = 1'h1;
    cyc(5);
    chk("en", 4'h4, ens);
    chk("pin", 4'h1, z(switcher_pin_status));
    lin_drive = 1'h1;
    cyc(5);
    chk("en", 4'h7, ens);
    fw_latch_regs = 1'h1;
    cyc(1);
    {fw_latch_regs, sw_drive, lin_drive} = 3'h0;
    cyc(6);
    chk("en", 4'h7, ens);
    chk("pin", 4'h0, z(switcher_pin_status));
  endtask
  task automatic t_rst;
    rst_drive = 1'h1;
    cyc(FILT / 2);
    rst_drive = 1'h0;
    cyc(FILT);
    chk("short", 4'h0, z(chip_reset));
    rst_drive = 1'h1;
    wait_rst(FILT + 6);
    cyc(FILT * 3 / 2);
    chk("pads", 4'h3, {2'h0, pads_input_only, clk_safe_slow});
    chk("lp", 4'h7, lps);
    chk("tx", UD, {pad_pull.uart_tx, pad_pull.uart_rx});
    chk("rts", UD, {pad_pull.uart_rts, pad_pull.uart_cts});
    chk("cs", UD, {pad_pull.spi_cs, pad_pull.spi_clk});
    chk("rst", UD, {pad_pull.rst_pin, pad_pull.spi_mosi});
    chk("miso", DD, {pad_pull.spi_miso, pad_pull.test_en});
    chk("pio", 4'h1, {2'h0, pad_pull.programmable_io_pins});
    io_before_core = 1'h1;
    cyc(3);
    chk("io", DD, {pad_pull.uart_tx, pad_pull.rst_pin});
    {io_before_core, rst_drive} = 2'h0;
    cyc(6);
    chk("end", 4'h0, {2'h0, chip_reset, cold_reset});
    chk("en", 4'h0, ens);
    for (int i = 0; i < 3; i++)
    begin
      {por_active, uart_break, wdog_expire} = 3'h1 << i;
      cyc(1);
      {por_active, uart_break, wdog_expire} = 3'h0;
      wait_rst(3);
      chk("cold", z(i == 2), z(cold_reset));
      cyc(4);
      chk("end", 4'h0, z(chip_reset));
    end
  endtask
  task automatic t_fw;
    {fw_linear_req, deep_sleep, audio_cells_on} = 3'h6;
    cyc(4);
    chk("en", 4'h3, ens);
    chk("lp", 4'h7, lps);
    {fw_linear_req, deep_sleep, audio_cells_on, fw_switcher_req} = 4'h3;
    cyc(4);
    chk("en", 4'h4, ens);
    chk("lp", 4'h0, lps);
    fw_switcher_req = 1'h0;
    cyc(4);
    chk("en", 4'h0, ens);
  endtask
  task automatic t_chg;
    fast_charge_current_setting = 4'ha;
    plug = 1'h1;
    step(13'h9c4, CHG_TRICKLE);
    chk("trk", 4'h3, {2'h0, chg_trickle_on, chg_supply_present});
    chk("en", 4'h7, ens);
    step(13'hdac, CHG_FAST_CC);
    chk("cur", 4'ha, chg_current);
    step(13'h1068, CHG_FAST_CV);
    chk("cv", 4'h1, z(chg_cv_on));
    taper = 1'h1;
    step(13'h1068, CHG_STANDBY);
    chk("cur", 4'h0, chg_current);
    taper = 1'h0;
    step(13'h1004, CHG_STANDBY);
    step(13'hfa0, CHG_FAST_CC);
    plug = 1'h0;
    step(13'hfa0, CHG_OFF);
    chk("sup", 4'h0, z(chg_supply_present));
  endtask

  initial
  begin
    cyc(6);
    rst_b = 1'h1;
    t_boot();
    t_rst();
    t_fw();
    t_chg();
    test_done();
  end
endmodule // tb_top
